// ==== hdl/switch_cfg_regs.v ====
// Purpose: serial-loaded configuration banks for a two-channel load switch
// Assumes: SPI mode 0, chip select active low, even parity over the word
// Notes: serial pins are resynchronised to clk_i; one bank per channel
`timescale 1ns/10ps
`include "switch_cfg_defs.vh"
module switch_cfg_regs (
    input wire clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire csb_n_i,
    input wire si_i,
    input wire ext_clk_i,
    input wire [1:0] direct_in_i,
    input wire [1:0] load_type_input_i,
    input wire [1:0] duty_run_i,
    input wire [1:0] oc_window_i,
    output reg [1:0] channel_on_o,
    output reg [1:0] short_to_supply_detect_on_o,
    output reg [1:0] on_state_open_load_on_o,
    output reg [1:0] off_state_open_load_on_o,
    output reg [3:0] slew_rate_o,
    output reg [3:0] upper_threshold_o,
    output reg [3:0] middle_threshold_o,
    output reg [3:0] low_threshold_o,
    output reg [1:0] sense_ratio_low_o,
    output reg [1:0] threshold_third_o,
    output reg [1:0] sense_available_o,
    output reg [3:0] window1_sel_o,
    output reg [3:0] window2_sel_o,
    output reg [1:0] middle_active_o,
    output reg [3:0] readback_sel_o,
    output reg watchdog_toggle_bit_o,
    output reg parity_fault_o
);

    // Per-channel registers
    reg [8:0] duty_q [0:1];
    reg [8:0] load_type_input_q [0:1];
    reg [8:0] ocr_q [0:1];
    reg [2:0] sclk_s_q, csb_s_q, si_s_q, ext_s_q;
    reg sclk_v_q, csb_v_q, ext_v_q;
    reg [15:0] shift_q;
    reg [4:0] bits_q;
    reg [9:0] div_q [0:1];
    reg [7:0] phase_q [0:1];
    reg [2:0] dly_q [0:1];
    reg [1:0] dly_done_q;
    reg [1:0] run_q;
    // Loop indexes, one per process
    integer i;
    integer j;
    integer k;
    integer n;

    // Divider length from clock source and prescale choice
    function [9:0] div_len;
        input [8:0] ocr;
        begin
            // Internal clock: fixed step length in system clocks
            if (ocr[`OCR_INT_CLK])
                div_len = `INT_DIV;
            // External clock: period divider spread over the 256 steps
            else if (ocr[`OCR_DIV_SEL])
                div_len = `DIV_LONG >> 8;
            else
                div_len = `DIV_SHORT >> 8;
        end
    endfunction

    // Three-stage synchronisers; sclk, csb and ext change accepted when stages 2 and 3 agree, si taken from stage 3 as is
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_s_q <= 3'h0;
            csb_s_q <= 3'h7;
            si_s_q <= 3'h0;
            ext_s_q <= 3'h0;
            sclk_v_q <= 1'b0;
            csb_v_q <= 1'b1;
            ext_v_q <= 1'b0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            csb_s_q <= {csb_s_q[1:0], csb_n_i};
            si_s_q <= {si_s_q[1:0], si_i};
            ext_s_q <= {ext_s_q[1:0], ext_clk_i};
            if (sclk_s_q[1] == sclk_s_q[2])
                sclk_v_q <= sclk_s_q[2];
            if (csb_s_q[1] == csb_s_q[2])
                csb_v_q <= csb_s_q[2];
            if (ext_s_q[1] == ext_s_q[2])
                ext_v_q <= ext_s_q[2];
        end
    end

    // Edge strobes from the filtered pins and word fields
    wire sclk_rise = (sclk_s_q[1] == sclk_s_q[2]) && sclk_s_q[2] && !sclk_v_q;
    wire csb_rise = (csb_s_q[1] == csb_s_q[2]) && csb_s_q[2] && !csb_v_q;
    wire ext_rise = (ext_s_q[1] == ext_s_q[2]) && ext_s_q[2] && !ext_v_q;
    wire word_ok = (bits_q == 5'h10);
    wire par_ok = ~^shift_q;
    wire bank = shift_q[`BANK_BIT];
    wire [2:0] addr = shift_q[`ADDR_HI:`ADDR_LO];
    wire [8:0] field = shift_q[`FIELD_HI:0];

    // Shift in word, decode on chip-select release
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shift_q <= 16'h0000;
            bits_q <= 5'h00;
            readback_sel_o <= 4'h0;
            watchdog_toggle_bit_o <= 1'b0;
            parity_fault_o <= 1'b0;
            for (j = 0; j < 2; j = j + 1)
            begin
                duty_q[j] <= `FIELD_RESET;
                load_type_input_q[j] <= `FIELD_RESET;
                ocr_q[j] <= `FIELD_RESET;
            end
        end
        else if (csb_rise)
        begin
            bits_q <= 5'h00;
            // Only a word of exactly 16 bits is looked at
            if (word_ok)
            begin
                watchdog_toggle_bit_o <= shift_q[`WD_BIT];
                parity_fault_o <= !par_ok;
                // Bad parity updates the status bits only
                if (par_ok)
                begin
                    case (addr)
                        `ADDR_RDSEL: readback_sel_o <= {bank, field[2:0]};
                        `ADDR_DUTY: duty_q[bank] <= field;
                        `ADDR_LOAD_TYPE_INPUT: load_type_input_q[bank] <= field;
                        `ADDR_OCR: ocr_q[bank] <= field;
                        default: ;
                    endcase
                end
            end
        end
        else if (!csb_v_q && sclk_rise)
        begin
            shift_q <= {shift_q[14:0], si_s_q[2]};
            // Saturate so that long frames stay refused
            if (bits_q != 5'h1f)
                bits_q <= bits_q + 5'h01;
        end
    end

    // Duty-cycle engine per channel: prescaler, delay, 256-step phase
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_q <= 2'h0;
            dly_done_q <= 2'h0;
            for (i = 0; i < 2; i = i + 1)
            begin
                div_q[i] <= 10'h000;
                phase_q[i] <= 8'h00;
                dly_q[i] <= 3'h0;
            end
        end
        else
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                run_q[i] <= duty_run_i[i] & duty_q[i][`DUTY_EN];
                if (!run_q[i])
                begin
                    div_q[i] <= 10'h000;
                    phase_q[i] <= 8'h00;
                    dly_q[i] <= 3'h0;
                    // Idle: a zero delay lets the first step switch on at once
                    dly_done_q[i] <= (load_type_input_q[i][2:0] == 3'h0);
                end
                else if (ocr_q[i][`OCR_INT_CLK] || ext_rise)
                begin
                    if (div_q[i] >= div_len(ocr_q[i]) - 10'h001)
                    begin
                        div_q[i] <= 10'h000;
                        // Delay counts whole steps before the phase starts
                        if (!dly_done_q[i])
                        begin
                            dly_q[i] <= dly_q[i] + 3'h1;
                            if (dly_q[i] + 3'h1 == load_type_input_q[i][2:0])
                                dly_done_q[i] <= 1'b1;
                        end
                        else
                            phase_q[i] <= phase_q[i] + 8'h01;
                    end
                    else
                        div_q[i] <= div_q[i] + 10'h001;
                end
            end
        end
    end

    // Channel drive, detection enables and slew
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Detection enabled, channel off
            channel_on_o <= 2'h0;
            short_to_supply_detect_on_o <= 2'h3;
            on_state_open_load_on_o <= 2'h3;
            off_state_open_load_on_o <= 2'h3;
            slew_rate_o <= 4'h0;
            sense_available_o <= 2'h0;
        end
        else
        begin
            for (k = 0; k < 2; k = k + 1)
            begin
                // Direct input allowed unless blocked; duty function always counts
                channel_on_o[k] <= (run_q[k] && dly_done_q[k] &&
                    phase_q[k] < duty_q[k][7:0]) ||
                    (!load_type_input_q[k][`LOAD_TYPE_INPUT_DIR_BLOCK] && direct_in_i[k]);
                short_to_supply_detect_on_o[k] <= !load_type_input_q[k][`LOAD_TYPE_INPUT_OS_OFF];
                on_state_open_load_on_o[k] <= !load_type_input_q[k][`LOAD_TYPE_INPUT_OLON_OFF];
                off_state_open_load_on_o[k] <= !load_type_input_q[k][`LOAD_TYPE_INPUT_OLOFF_OFF];
                // 0 medium, 1 low, 2 high, 3 medium-high
                slew_rate_o[2*k +: 2] <= load_type_input_q[k][4:3];
                // Sense withheld while a window is open
                sense_available_o[k] <= !oc_window_i[k];
            end
        end
    end

    // Threshold, sense ratio and window decode
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // All codes at their default levels
            upper_threshold_o <= 4'h0;
            middle_threshold_o <= 4'h0;
            low_threshold_o <= 4'h0;
            sense_ratio_low_o <= 2'h0;
            threshold_third_o <= 2'h0;
            window1_sel_o <= 4'h0;
            window2_sel_o <= 4'h0;
            middle_active_o <= 2'h0;
        end
        else
        begin
            for (n = 0; n < 2; n = n + 1)
            begin
                // Threshold codes: 0 is the higher value
                upper_threshold_o[2*n +: 2] <= {1'b0, ocr_q[n][`OCR_UPPER]};
                middle_threshold_o[2*n +: 2] <= load_type_input_i[n] ? 2'h0 :
                    {1'b0, ocr_q[n][`OCR_MIDDLE]};
                // 0 highest, 1 middle, 2 lowest
                low_threshold_o[2*n +: 2] <= !ocr_q[n][`OCR_LOW_RANGE] ? 2'h0 :
                    (ocr_q[n][`OCR_LOW] ? 2'h2 : 2'h1);
                sense_ratio_low_o[n] <= ocr_q[n][`OCR_SENSE_LOW];
                threshold_third_o[n] <= ocr_q[n][`OCR_SENSE_LOW];
                middle_active_o[n] <= !load_type_input_i[n];
                // Bulb: two width bits; motor: one of four windows in window1_sel
                if (load_type_input_i[n])
                begin
                    window1_sel_o[2*n +: 2] <= ocr_q[n][4:3];
                    window2_sel_o[2*n +: 2] <= 2'h0;
                end
                else
                begin
                    window1_sel_o[2*n +: 2] <= {1'b0, ocr_q[n][`OCR_WIN1]};
                    window2_sel_o[2*n +: 2] <= {1'b0, ocr_q[n][`OCR_WIN2]};
                end
            end
        end
    end

endmodule

// ==== hdl/switch_cfg_defs.vh ====
// Purpose: constants for the two-bank serial configuration register block
// Assumes: 16-bit serial words, MSB first
// Notes: field positions are bit indexes in the 16-bit word or 9-bit field
`ifndef SWITCH_CFG_DEFS_VH
`define SWITCH_CFG_DEFS_VH
`define WORD_BITS 16
`define WD_BIT 15
`define PAR_BIT 14
`define BANK_BIT 13
`define ADDR_HI 12
`define ADDR_LO 10
`define FIELD_HI 8
`define ADDR_RDSEL 3'h0
`define ADDR_DUTY 3'h1
`define ADDR_LOAD_TYPE_INPUT 3'h2
`define ADDR_OCR 3'h4
`define FIELD_RESET 9'h000
`define DUTY_EN 8
`define LOAD_TYPE_INPUT_OS_OFF 8
`define LOAD_TYPE_INPUT_OLON_OFF 7
`define LOAD_TYPE_INPUT_OLOFF_OFF 6
`define LOAD_TYPE_INPUT_DIR_BLOCK 5
`define OCR_LOW_RANGE 8
`define OCR_DIV_SEL 7
`define OCR_INT_CLK 6
`define OCR_SENSE_LOW 5
`define OCR_WIN1 4
`define OCR_WIN2 3
`define OCR_UPPER 2
`define OCR_MIDDLE 1
`define OCR_LOW 0
`define DIV_SHORT 10'h100
`define DIV_LONG 10'h200
`define INT_DIV 10'h0fa
`endif

// ==== tb/spi_host_model.sv ====
// Purpose: serial host that clocks words into the config block
// Assumes: mode 0, MSB first, 4 clocks per serial clock phase
// Notes: data line shows inverse of last bit while deselected
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk_i,
    output logic sclk_o,
    output logic csb_n_o,
    output logic si_o
);
    // Idle bus
    initial
    begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        si_o = 1'b0;
    end
    // Shift nbits of w, MSB first
    task automatic xfer(input logic [15:0] w, input int nbits);
        @(negedge clk_i);
        csb_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            si_o = w[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        csb_n_o = 1'b1;
        si_o = ~si_o;
    endtask
endmodule

// ==== tb/switch_cfg_regs_asserts.sv ====
// Purpose: port-level checks of the config banks
// Assumes: one clock, reset high
// Notes: channel 0 in low bits of packed outputs
`timescale 1ns/10ps
module switch_cfg_regs_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire csb_n_i,
    input wire [1:0] load_type_input_i,
    input wire [1:0] oc_window_i,
    input wire [1:0] short_to_supply_detect_on_o,
    input wire [3:0] slew_rate_o,
    input wire [3:0] middle_threshold_o,
    input wire [1:0] middle_active_o,
    input wire [1:0] sense_ratio_low_o,
    input wire [1:0] threshold_third_o,
    input wire [1:0] sense_available_o,
    input wire [3:0] window1_sel_o,
    input wire [3:0] window2_sel_o,
    input wire parity_fault_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst_en; $fell(rst_i) |-> short_to_supply_detect_on_o == 2'h3; endproperty
    a_rst_en: assert property (p_rst_en) else $error("detect off after reset");
    property p_sns0; oc_window_i[0] |=> !sense_available_o[0]; endproperty
    a_sns0: assert property (p_sns0) else $error("sense during window");
    property p_sns1; !oc_window_i[1] |=> sense_available_o[1]; endproperty
    a_sns1: assert property (p_sns1) else $error("sense lost");
    property p_third; threshold_third_o == sense_ratio_low_o; endproperty
    a_third: assert property (p_third) else $error("third mismatch");
    property p_mid; load_type_input_i[0] [*3] |-> middle_threshold_o[1:0] == 2'h0; endproperty
    a_mid: assert property (p_mid) else $error("middle in motor");
    property p_mact; load_type_input_i[0] [*3] |-> !middle_active_o[0]; endproperty
    a_mact: assert property (p_mact) else $error("middle active");
    property p_wmot; load_type_input_i[0] [*3] |-> window2_sel_o[1:0] == 2'h0; endproperty
    a_wmot: assert property (p_wmot) else $error("motor window");
    property p_wblb; !load_type_input_i[0] [*3] |-> !window1_sel_o[1]; endproperty
    a_wblb: assert property (p_wblb) else $error("bulb window");
    property p_quiet; csb_n_i [*8] |=> $stable(slew_rate_o); endproperty
    a_quiet: assert property (p_quiet) else $error("change without word");
    property p_par; $rose(parity_fault_o) |=> $stable(slew_rate_o); endproperty
    a_par: assert property (p_par) else $error("write on bad parity");
endmodule
bind switch_cfg_regs switch_cfg_regs_asserts chk (.clk_i, .rst_i, .csb_n_i,
    .load_type_input_i, .oc_window_i, .short_to_supply_detect_on_o, .slew_rate_o,
    .middle_threshold_o, .middle_active_o, .sense_ratio_low_o, .threshold_third_o,
    .sense_available_o, .window1_sel_o, .window2_sel_o, .parity_fault_o);

// ==== tb/test_switch_cfg_regs.sv ====
// Purpose: word-level test of the serial config banks
// Assumes: outputs settled 12 clocks after a frame ends
// Notes: external clock pin runs at one eighth of clk_i
`timescale 1ns/10ps
`include "switch_cfg_defs.vh"
module test_switch_cfg_regs;
    logic clk_i, rst_i, ext_clk_i, wd;
    logic [1:0] direct_in_i, load_type_input_i, duty_run_i, oc_window_i;
    wire sclk_i, csb_n_i, si_i, watchdog_toggle_bit_o, parity_fault_o;
    wire [1:0] channel_on_o, short_to_supply_detect_on_o, on_state_open_load_on_o;
    wire [1:0] off_state_open_load_on_o, sense_ratio_low_o, threshold_third_o;
    wire [1:0] sense_available_o, middle_active_o;
    wire [3:0] slew_rate_o, upper_threshold_o, middle_threshold_o, low_threshold_o;
    wire [3:0] window1_sel_o, window2_sel_o, readback_sel_o;
    int n_fail = 0;
    int n_tests = 0;
    logic [2:0] ext_cnt;
    logic [8:0] ocr_f [3] = '{9'h001, 9'h126, 9'h11f};
    logic [8:0] ocr_e [3] = '{9'h000, 9'h170, 9'h0b5};
    spi_host_model host (.clk_i, .sclk_o(sclk_i), .csb_n_o(csb_n_i), .si_o(si_i));
    switch_cfg_regs uut (.clk_i, .rst_i, .sclk_i, .csb_n_i, .si_i, .ext_clk_i,
        .direct_in_i, .load_type_input_i, .duty_run_i, .oc_window_i, .channel_on_o,
        .short_to_supply_detect_on_o, .on_state_open_load_on_o, .off_state_open_load_on_o,
        .slew_rate_o, .upper_threshold_o, .middle_threshold_o, .low_threshold_o,
        .sense_ratio_low_o, .threshold_third_o, .sense_available_o, .window1_sel_o,
        .window2_sel_o, .middle_active_o, .readback_sel_o, .watchdog_toggle_bit_o,
        .parity_fault_o);
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Even-parity word, toggled watchdog, optional parity slip
    task automatic put(input logic b, input logic [2:0] a, input logic [8:0] f, input logic bad);
        logic [15:0] w;
        wd = ~wd;
        w = {wd, 1'b0, b, a, 1'b0, f};
        w[14] = ^w ^ bad;
        host.xfer(w, 16);
        repeat (12) @(negedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Full high pulse of channel 1 in external clock periods (8 clocks each)
    task automatic pulse_len(output logic [8:0] steps);
        int n;
        int t;
        n = 0;
        t = 0;
        while (channel_on_o[1] !== 1'b0 && t < 9000)
        begin
            @(negedge clk_i);
            t++;
        end
        while (channel_on_o[1] !== 1'b1 && t < 9000)
        begin
            @(negedge clk_i);
            t++;
        end
        while (channel_on_o[1] === 1'b1 && t < 9000)
        begin
            @(negedge clk_i);
            t++;
            n++;
        end
        if (t >= 9000)
        begin
            n_fail++;
            tally_and_finish;
        end
        else
        begin
            n = (n + 4) >> 3;
            steps = n[8:0];
        end
    endtask
    // External clock pin, one eighth of clk_i
    always @(negedge clk_i)
        ext_cnt <= rst_i ? 3'h0 : ext_cnt + 3'h1;
    assign ext_clk_i = ext_cnt[2];
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Hang guard
    initial
    begin
        #3000000;
        n_fail++;
        tally_and_finish;
    end
    initial
    begin
        logic [1:0] i;
        logic [8:0] len;
        rst_i = 1'b1;
        wd = 1'b0;
        direct_in_i = 2'h1;
        load_type_input_i = 2'h0;
        duty_run_i = 2'h3;
        oc_window_i = 2'h1;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk({1'b0, short_to_supply_detect_on_o, on_state_open_load_on_o,
            off_state_open_load_on_o, channel_on_o}, 9'h0fd);
        chk({7'h0, sense_available_o}, 9'h002);
        for (int k = 0; k < 4; k++)
        begin
            i = k[1:0];
            put(1'b0, `ADDR_LOAD_TYPE_INPUT, {i[0], i[1], ~i[0], 1'b0, i, 3'h0}, 1'b0);
            chk({4'h0, short_to_supply_detect_on_o[0], on_state_open_load_on_o[0],
                off_state_open_load_on_o[0], slew_rate_o[1:0]},
                {4'h0, ~i[0], ~i[1], i[0], i});
        end
        put(1'b0, `ADDR_LOAD_TYPE_INPUT, 9'h020, 1'b0);
        chk({7'h0, channel_on_o}, 9'h000);
        put(1'b1, `ADDR_LOAD_TYPE_INPUT, 9'h018, 1'b0);
        chk({5'h0, slew_rate_o}, 9'h00c);
        for (int k = 0; k < 3; k++)
        begin
            put(1'b0, `ADDR_OCR, ocr_f[k], 1'b0);
            chk({threshold_third_o[0], low_threshold_o[1:0], upper_threshold_o[0],
                middle_threshold_o[0], window1_sel_o[1:0], window2_sel_o[1:0]},
                ocr_e[k]);
        end
        load_type_input_i = 2'h1;
        repeat (4) @(negedge clk_i);
        chk({threshold_third_o[0], low_threshold_o[1:0], upper_threshold_o[0],
            middle_threshold_o[0], window1_sel_o[1:0], window2_sel_o[1:0]}, 9'h0ac);
        chk({7'h0, middle_active_o}, 9'h002);
        put(1'b1, `ADDR_LOAD_TYPE_INPUT, 9'h000, 1'b1);
        chk({4'h0, parity_fault_o, slew_rate_o}, 9'h01c);
        host.xfer(16'h4800, 15);
        repeat (12) @(negedge clk_i);
        chk({4'h0, parity_fault_o, slew_rate_o}, 9'h01c);
        put(1'b1, `ADDR_RDSEL, 9'h005, 1'b0);
        chk({5'h0, readback_sel_o}, 9'h00d);
        chk({7'h0, parity_fault_o, watchdog_toggle_bit_o}, {8'h0, wd});
        put(1'b1, `ADDR_DUTY, 9'h180, 1'b0);
        pulse_len(len);
        chk(len, 9'h080);
        put(1'b1, `ADDR_OCR, 9'h080, 1'b0);
        pulse_len(len);
        chk(len, 9'h100);
        put(1'b1, `ADDR_DUTY, 9'h080, 1'b0);
        chk({8'h0, channel_on_o[1]}, 9'h000);
        tally_and_finish;
    end
endmodule
